// File: inc/ucp_pkg.sv
// Constants, register map, field layout and parity helpers for the character-level serial block.
package ucp_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register offsets (byte addresses)
  localparam logic [7:0] COMMAND_REG_OFS        = 8'h00;
  localparam logic [7:0] MAIN_MODE_REG_OFS      = 8'h04;
  localparam logic [7:0] CHANNEL_STATUS_REG_OFS = 8'h14;
  localparam logic [7:0] RX_HOLDING_REG_OFS     = 8'h18;
  localparam logic [7:0] TX_HOLDING_REG_OFS     = 8'h1C;
  localparam logic [7:0] GUARD_TIME_REG_OFS     = 8'h28;

  // Command register bits
  localparam int unsigned CMD_CLEAR_STATUS_BIT = 8;
  localparam int unsigned CMD_SEND_ADDRESS_BIT = 12;

  // Mode register fields
  localparam int unsigned MODE_CLOCKED_BIT  = 8;
  localparam int unsigned MODE_PAR_LSB      = 9;
  localparam int unsigned MODE_TWO_STOP_BIT = 12;

  // Status register bits
  localparam int unsigned STAT_RX_READY_BIT = 0;
  localparam int unsigned STAT_TX_FREE_BIT  = 1;
  localparam int unsigned STAT_OVERRUN_BIT  = 5;
  localparam int unsigned STAT_PAR_ERR_BIT  = 7;
  localparam int unsigned STAT_TX_IDLE_BIT  = 9;

  // Parity-select encodings
  localparam logic [2:0] PAR_EVEN  = 3'h0;
  localparam logic [2:0] PAR_ODD   = 3'h1;
  localparam logic [2:0] PAR_SPACE = 3'h2;
  localparam logic [2:0] PAR_MARK  = 3'h3;
  localparam logic [2:0] PAR_NONE  = 3'h4;
  localparam logic [2:0] PAR_NONE2 = 3'h5;
  localparam logic [2:0] PAR_MD_A  = 3'h6;
  localparam logic [2:0] PAR_MD_B  = 3'h7;

  // Reset values and data bits per character
  localparam logic [2:0] PAR_RESET   = 3'h0;
  localparam logic [7:0] GUARD_RESET = 8'h00;
  localparam logic [3:0] DATA_BITS   = 4'h8;

  // True when the mode puts a parity bit in the frame
  function automatic logic has_parity(input logic [2:0] mode);
    has_parity = (mode != PAR_NONE) && (mode != PAR_NONE2);
  endfunction : has_parity

  // Parity bit value for a character; addr marks a multidrop address
  function automatic logic parity_bit(input logic [2:0] mode, input logic [7:0] data,
                                      input logic addr);
    unique case (mode)
      PAR_EVEN:          parity_bit = ^data;
      PAR_ODD:           parity_bit = ~^data;
      PAR_SPACE:         parity_bit = 1'b0;
      PAR_MARK:          parity_bit = 1'b1;
      PAR_MD_A, PAR_MD_B: parity_bit = addr;
      default:           parity_bit = 1'b0;
    endcase
  endfunction : parity_bit
endpackage : ucp_pkg

// File: inc/ucp_tx_if.sv
// Link between the register core and the transmit character engine.
`timescale 1ns/10ps
`default_nettype none
interface ucp_tx_if;
  logic       load;
  logic [7:0] data;
  logic       addr_bit;
  logic [2:0] par_mode;
  logic       two_stop;
  logic [7:0] guard;
  logic       baud_tick;
  logic       holding_free;
  logic       idle;
  logic       txd;

  modport ctl (output load, data, addr_bit, par_mode, two_stop, guard, baud_tick,
               input holding_free, idle, txd);
  modport eng (input load, data, addr_bit, par_mode, two_stop, guard, baud_tick,
               output holding_free, idle, txd);
endinterface : ucp_tx_if
`default_nettype wire

// File: verilog/ucp_tx.sv
// Transmit engine: holding register, shifter, parity, stop bits and guard time.
`timescale 1ns/10ps
`default_nettype none
module ucp_tx (
  input  wire logic ref_clk,
  input  wire logic reset,
  ucp_tx_if.eng     tif
);
  typedef enum logic [2:0] {T_IDLE, T_DATA, T_PAR, T_STOP, T_GUARD} ucp_tx_state_t;

  typedef struct packed {
    ucp_tx_state_t state;
    logic [7:0]    cnt;
    logic [7:0]    shift;
    logic          shift_addr;
    logic [7:0]    hold;
    logic          hold_addr;
    logic          hold_valid;
    logic          txd;
  } ucp_tx_st_t;

  ucp_tx_st_t st_r;
  ucp_tx_st_t st_nxt;
  logic       finish;
  logic       start;

  // Next-state logic; each tick ends the bit on the line
  always_comb begin
    st_nxt = st_r;
    finish = 1'b0;
    if (tif.baud_tick) begin
      unique case (st_r.state)
        T_IDLE: ;
        T_DATA: begin
          if (st_r.cnt == 8'(ucp_pkg::DATA_BITS)) begin
            if (ucp_pkg::has_parity(tif.par_mode)) begin
              st_nxt.state = T_PAR;
              st_nxt.txd   = ucp_pkg::parity_bit(tif.par_mode, st_r.shift, st_r.shift_addr);
            end else begin
              st_nxt.state = T_STOP;
              st_nxt.cnt   = 8'h01;
              st_nxt.txd   = 1'b1;
            end
          end else begin
            st_nxt.txd = st_r.shift[st_r.cnt[2:0]];
            st_nxt.cnt = st_r.cnt + 8'h01;
          end
        end
        T_PAR: begin
          st_nxt.state = T_STOP;
          st_nxt.cnt   = 8'h01;
          st_nxt.txd   = 1'b1;
        end
        T_STOP: begin
          if (st_r.cnt == (tif.two_stop ? 8'h02 : 8'h01)) begin
            if (tif.guard != ucp_pkg::GUARD_RESET) begin
              st_nxt.state = T_GUARD;
              st_nxt.cnt   = 8'h01;
            end else begin
              finish = 1'b1;
            end
          end else begin
            st_nxt.cnt = st_r.cnt + 8'h01;
          end
        end
        T_GUARD: begin
          if (st_r.cnt >= tif.guard) finish = 1'b1;
          else st_nxt.cnt = st_r.cnt + 8'h01;
        end
        default: st_nxt.state = T_IDLE;
      endcase
    end
    if (finish) st_nxt.state = T_IDLE;
    // Holding register moves to the shifter only as a start bit goes out
    start = tif.baud_tick && st_r.hold_valid && (finish || st_r.state == T_IDLE);
    if (start) begin
      st_nxt.state      = T_DATA;
      st_nxt.cnt        = 8'h00;
      st_nxt.txd        = 1'b0;
      st_nxt.shift      = st_r.hold;
      st_nxt.shift_addr = st_r.hold_addr;
      st_nxt.hold_valid = 1'b0;
    end
    // A software write refills the holding register
    if (tif.load) begin
      st_nxt.hold       = tif.data;
      st_nxt.hold_addr  = tif.addr_bit;
      st_nxt.hold_valid = 1'b1;
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_r <= '{state: T_IDLE, txd: 1'b1, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Flags seen by software
  assign tif.holding_free = !st_r.hold_valid;
  assign tif.idle         = (st_r.state == T_IDLE) && !st_r.hold_valid;
  assign tif.txd          = st_r.txd;
endmodule : ucp_tx
`default_nettype wire

// File: verilog/ucp_top.sv
// Character-level serial block: registers, clocked receiver and transmit engine.
`timescale 1ns/10ps
`default_nettype none
module ucp_top (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic        baud_clk,
  input  wire logic        rxd,
  output logic             txd
);

  // Receiver states
  typedef enum logic [1:0] {R_IDLE, R_DATA, R_PAR, R_STOP} ucp_rx_state_t;

  // Whole state of the core in one record
  typedef struct packed {
    logic          baud_prev;
    logic          clocked;
    logic [2:0]    par_mode;
    logic          two_stop;
    logic [7:0]    guard;
    logic          addr_pend;
    ucp_rx_state_t rx_state;
    logic [3:0]    rx_cnt;
    logic [7:0]    rx_shift;
    logic          rx_par;
    logic [7:0]    rx_hold;
    logic          rx_ready;
    logic          overrun;
    logic          par_err;
    logic [31:0]   rdata;
  } ucp_core_st_t;

  ucp_core_st_t st_r;
  ucp_core_st_t st_nxt;

  // Decoded bus and line events
  logic baud_tick;
  logic wr_cmd;
  logic wr_mode;
  logic wr_guard;
  logic wr_thr;
  logic rd_rhr;
  logic clr_status;
  logic rx_done;
  logic rx_bad_par;

  ucp_tx_if tif ();

  // Transmit engine
  ucp_tx u_tx (
    .ref_clk (ref_clk),
    .reset   (reset),
    .tif     (tif)
  );

  // Baud clock rising edge
  assign baud_tick = baud_clk && !st_r.baud_prev;

  // Register decode
  assign wr_cmd     = reg_wr && (reg_addr == ucp_pkg::COMMAND_REG_OFS);
  assign wr_mode    = reg_wr && (reg_addr == ucp_pkg::MAIN_MODE_REG_OFS);
  assign wr_guard   = reg_wr && (reg_addr == ucp_pkg::GUARD_TIME_REG_OFS);
  assign wr_thr     = reg_wr && (reg_addr == ucp_pkg::TX_HOLDING_REG_OFS);
  assign rd_rhr     = reg_rd && (reg_addr == ucp_pkg::RX_HOLDING_REG_OFS);
  assign clr_status = wr_cmd && reg_wdata[ucp_pkg::CMD_CLEAR_STATUS_BIT];

  // Hand configuration and writes to the transmit engine
  assign tif.load      = wr_thr;
  assign tif.data      = reg_wdata[7:0];
  assign tif.addr_bit  = st_r.addr_pend;
  assign tif.par_mode  = st_r.par_mode;
  assign tif.two_stop  = st_r.two_stop;
  assign tif.guard     = st_r.guard;
  assign tif.baud_tick = baud_tick;

  // Mismatch between sampled and expected parity
  assign rx_bad_par = ucp_pkg::has_parity(st_r.par_mode) &&
                      (st_r.rx_par != ucp_pkg::parity_bit(st_r.par_mode,
                                                          st_r.rx_shift, 1'b0));

  // Last stop bit of a character sampled
  assign rx_done = baud_tick && (st_r.rx_state == R_STOP) &&
                   (st_r.rx_cnt == (st_r.two_stop ? 4'h1 : 4'h0));

  // Next-state logic
  always_comb begin
    st_nxt           = st_r;
    st_nxt.baud_prev = baud_clk;

    // Configuration writes
    if (wr_mode) begin
      st_nxt.clocked  = reg_wdata[ucp_pkg::MODE_CLOCKED_BIT];
      st_nxt.par_mode = reg_wdata[ucp_pkg::MODE_PAR_LSB +: 3];
      st_nxt.two_stop = reg_wdata[ucp_pkg::MODE_TWO_STOP_BIT];
    end
    if (wr_guard) begin
      st_nxt.guard = reg_wdata[7:0];
    end

    // Address marker for the next byte written
    if (wr_thr) begin
      st_nxt.addr_pend = 1'b0;
    end
    if (wr_cmd && reg_wdata[ucp_pkg::CMD_SEND_ADDRESS_BIT]) begin
      st_nxt.addr_pend = 1'b1;
    end

    // Receiver sequence, one sample per baud clock rise
    if (baud_tick) begin
      unique case (st_r.rx_state)
        R_IDLE: begin
          if (st_r.clocked && !rxd) begin
            st_nxt.rx_state = R_DATA;
            st_nxt.rx_cnt   = 4'h0;
          end
        end
        R_DATA: begin
          st_nxt.rx_shift = {rxd, st_r.rx_shift[7:1]};
          st_nxt.rx_cnt   = st_r.rx_cnt + 4'h1;
          if (st_r.rx_cnt == ucp_pkg::DATA_BITS - 4'h1) begin
            st_nxt.rx_cnt   = 4'h0;
            st_nxt.rx_state = ucp_pkg::has_parity(st_r.par_mode) ? R_PAR : R_STOP;
          end
        end
        R_PAR: begin
          st_nxt.rx_par   = rxd;
          st_nxt.rx_state = R_STOP;
        end
        R_STOP: begin
          st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
          if (rx_done) begin
            st_nxt.rx_state = R_IDLE;
          end
        end
      endcase
    end

    // Status flags: clears first, so a same-cycle set wins
    if (rd_rhr) begin
      st_nxt.rx_ready = 1'b0;
    end
    if (clr_status) begin
      st_nxt.overrun = 1'b0;
      st_nxt.par_err = 1'b0;
    end
    if (rx_done) begin
      st_nxt.rx_hold  = st_r.rx_shift;
      st_nxt.rx_ready = 1'b1;
      if (st_r.rx_ready && !rd_rhr) begin
        st_nxt.overrun = 1'b1;
      end
      if (rx_bad_par) begin
        st_nxt.par_err = 1'b1;
      end
    end

    // Read data, valid the cycle after the strobe
    st_nxt.rdata = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        ucp_pkg::MAIN_MODE_REG_OFS: begin
          st_nxt.rdata[ucp_pkg::MODE_CLOCKED_BIT]    = st_r.clocked;
          st_nxt.rdata[ucp_pkg::MODE_PAR_LSB +: 3]   = st_r.par_mode;
          st_nxt.rdata[ucp_pkg::MODE_TWO_STOP_BIT]   = st_r.two_stop;
        end
        ucp_pkg::CHANNEL_STATUS_REG_OFS: begin
          st_nxt.rdata[ucp_pkg::STAT_RX_READY_BIT] = st_r.rx_ready;
          st_nxt.rdata[ucp_pkg::STAT_TX_FREE_BIT]  = tif.holding_free;
          st_nxt.rdata[ucp_pkg::STAT_OVERRUN_BIT]  = st_r.overrun;
          st_nxt.rdata[ucp_pkg::STAT_PAR_ERR_BIT]  = st_r.par_err;
          st_nxt.rdata[ucp_pkg::STAT_TX_IDLE_BIT]  = tif.idle;
        end
        ucp_pkg::RX_HOLDING_REG_OFS: begin
          st_nxt.rdata[7:0] = st_r.rx_hold;
        end
        ucp_pkg::GUARD_TIME_REG_OFS: begin
          st_nxt.rdata[7:0] = st_r.guard;
        end
        default: begin
          st_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_r <= '{rx_state: R_IDLE, par_mode: ucp_pkg::PAR_RESET,
                guard: ucp_pkg::GUARD_RESET, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign reg_rdata = st_r.rdata;
  assign txd       = tif.txd;
endmodule : ucp_top
`default_nettype wire

// File: verification/ucp_top_asserts.sv
// Checker of register replies, sticky flags and line pacing of the serial block.
`timescale 1ns/10ps
`default_nettype none
module ucp_top_asserts (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        baud_clk,
  input wire logic        rxd,
  input wire logic        txd
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic       st_r;
  logic       rh_r;
  logic       gd_r;
  logic       bc_r;
  logic [2:0] age_r;
  logic       ovr_r;
  logic       per_r;
  logic       rdy_r;
  logic       clr;
  logic       rhr;
  // Clear-status write and holding read strobes
  assign clr = reg_wr && reg_addr == ucp_pkg::COMMAND_REG_OFS
               && reg_wdata[ucp_pkg::CMD_CLEAR_STATUS_BIT];
  assign rhr = reg_rd && reg_addr == ucp_pkg::RX_HOLDING_REG_OFS;
  // Read decode, age of the last baud rise and flags seen set
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_r  <= 1'b0;
      rh_r  <= 1'b0;
      gd_r  <= 1'b0;
      bc_r  <= 1'b0;
      age_r <= 3'h7;
      ovr_r <= 1'b0;
      per_r <= 1'b0;
      rdy_r <= 1'b0;
    end else begin
      st_r  <= reg_rd && reg_addr == ucp_pkg::CHANNEL_STATUS_REG_OFS;
      rh_r  <= rhr;
      gd_r  <= reg_rd && reg_addr == ucp_pkg::GUARD_TIME_REG_OFS;
      bc_r  <= baud_clk;
      age_r <= (baud_clk && !bc_r) ? 3'h0 : age_r + {2'h0, age_r != 3'h7};
      ovr_r <= !clr && (ovr_r || (st_r && reg_rdata[5]));
      per_r <= !clr && (per_r || (st_r && reg_rdata[7]));
      rdy_r <= !rhr && (rdy_r || (st_r && reg_rdata[0]));
    end
  end
  chk_tx_on_tick: assert property ($changed(txd) |-> age_r <= 3'h3)
    else $error("txd moved away from a baud tick");
  chk_idle_free: assert property (st_r && reg_rdata[9] |-> reg_rdata[1])
    else $error("tx idle without holding free");
  chk_idle_high: assert property (st_r && reg_rdata[9] |-> txd)
    else $error("tx idle while line low");
  chk_ovr_held: assert property (st_r && ovr_r |-> reg_rdata[5])
    else $error("overrun dropped without clear");
  chk_perr_held: assert property (st_r && per_r |-> reg_rdata[7])
    else $error("check bit error dropped without clear");
  chk_ready_held: assert property (st_r && rdy_r |-> reg_rdata[0])
    else $error("rx ready dropped without read");
  chk_status_bits: assert property (st_r |-> (reg_rdata & ~32'h0000_02A3) == 32'h0)
    else $error("status has stray bits");
  chk_guard_width: assert property (gd_r |-> reg_rdata[31:8] == 24'h0)
    else $error("guard count wider than a byte");
  chk_rx_width: assert property (rh_r |-> reg_rdata[31:8] == 24'h0)
    else $error("rx holding wider than a byte");
  chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside reply cycle");
endmodule : ucp_top_asserts
bind ucp_top ucp_top_asserts i_chk (
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .baud_clk(baud_clk),
  .rxd(rxd), .txd(txd));
`default_nettype wire

// File: verification/ucp_far.sv
// Remote serial device: baud clock, character sender and line capture.
`timescale 1ns/10ps
`default_nettype none
module ucp_far (
  input  wire logic ref_clk,
  input  wire logic txd,
  output logic      baud_clk,
  output logic      rxd
);
  logic [2:0]  div_r = 3'h0;
  logic [10:0] frm_r = 11'h0;
  int          cnt_r = 0;
  int          idle_r = 0;
  int          gap_r = 0;
  int          frames_r = 0;
  // Baud clock runs free; the transmitter paces its own frames on it
  assign baud_clk = div_r[2];
  initial rxd = 1'b1;
  // Sample the line mid-bit; count idle bits between frames
  always @(posedge ref_clk) begin
    div_r <= div_r + 3'h1;
    if (div_r == 3'h7) begin
      if (cnt_r == 0 && !txd) begin
        frm_r[0] <= 1'b0;
        cnt_r    <= 1;
        gap_r    <= idle_r;
        idle_r   <= 0;
      end else if (cnt_r == 0) begin
        idle_r <= idle_r + 1;
      end else begin
        frm_r[cnt_r] <= txd;
        cnt_r        <= (cnt_r == 10) ? 0 : cnt_r + 1;
        frames_r     <= frames_r + int'(cnt_r == 10);
      end
    end
  end
  // One character: start, data LSB first, check bit, stop, idle
  task automatic send(input logic [7:0] d, input logic p);
    logic [11:0] f;
    f = {2'h3, p, d, 1'b0};
    for (int i = 0; i < 12; i++) begin
      @(posedge ref_clk iff div_r == 3'h7);
      rxd <= f[i];
    end
  endtask : send
endmodule : ucp_far
`default_nettype wire

// File: verification/tb_top.sv
// Testbench: register accesses, remote traffic and status checks.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [7:0]  PERR = 8'hC5;
  localparam logic [23:0] TXM = {3'h4, 3'h7, 3'h6, 3'h6, 3'h3, 3'h2, 3'h1, 3'h0};
  localparam logic [7:0]  TXP = 8'h9A;
  localparam logic [7:0]  TXA = 8'h10;
  localparam logic [7:0]  ST = ucp_pkg::CHANNEL_STATUS_REG_OFS;
  localparam logic [7:0]  MD = ucp_pkg::MAIN_MODE_REG_OFS;
  localparam logic [7:0]  GT = ucp_pkg::GUARD_TIME_REG_OFS;
  localparam logic [7:0]  TH = ucp_pkg::TX_HOLDING_REG_OFS;
  localparam logic [7:0]  RH = ucp_pkg::RX_HOLDING_REG_OFS;
  localparam logic [7:0]  CM = ucp_pkg::COMMAND_REG_OFS;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        baud_clk;
  logic        rxd;
  logic        txd;
  int          fails = 0;
  int          n_tests = 0;
  int          cycles = 0;
  ucp_top i_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .baud_clk(baud_clk), .rxd(rxd), .txd(txd));
  ucp_far i_far (.ref_clk(ref_clk), .txd(txd), .baud_clk(baud_clk), .rxd(rxd));
  // 25 MHz clock
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic close_out();
    $display("checks %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  // Hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask : rc
  task automatic wait_frame();
    int n;
    n = i_far.frames_r;
    repeat (400) begin
      @(posedge ref_clk);
      if (i_far.frames_r != n) break;
    end
    chk("frame end", 32'h1, {31'h0, i_far.frames_r != n});
  endtask : wait_frame
  task automatic pause(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : pause
  // Main sequence
  initial begin
    pause(3);
    reset <= 1'b0;
    rc(ST, 32'h0000_0202, "status reset");
    rc(MD, 32'h0, "mode reset");
    rc(8'h08, 32'h0, "unmapped");
    rc(TH, 32'h0, "tx holding read");
    wr(GT, 32'h0000_01FF);
    rc(GT, 32'h0000_00FF, "guard");
    wr(GT, 32'h0);
    // High check bit received in every mode
    for (int m = 0; m < 8; m++) begin
      wr(MD, 32'h0000_0100 | (32'(m) << 9));
      i_far.send(8'h41, 1'b1);
      rc(ST, 32'h0000_0203 | (32'(PERR[m]) << 7), "rx status");
      rc(RH, 32'h0000_0041, "rx data");
      wr(CM, 32'h0000_0100);
    end
    // Two characters unread: overrun, overwrite, sticky until cleared
    wr(MD, 32'h0000_0100);
    i_far.send(8'h41, 1'b0);
    i_far.send(8'h5A, 1'b0);
    rc(ST, 32'h0000_0223, "overrun");
    rc(RH, 32'h0000_005A, "overwrite");
    rc(ST, 32'h0000_0222, "overrun held");
    wr(CM, 32'h0000_0100);
    rc(ST, 32'h0000_0202, "cleared");
    // Transmitted check bit per mode, address mark in multidrop
    for (int i = 0; i < 8; i++) begin
      wr(MD, 32'(TXM[3*i +: 3]) << 9);
      if (TXA[i]) wr(CM, 32'h0000_1000);
      wr(TH, 32'h0000_0041);
      wait_frame();
      chk("tx frame", {21'h0, 1'b1, TXP[i], 8'h41, 1'b0}, {21'h0, i_far.frm_r});
    end
    // No guard: back-to-back characters
    wr(MD, 32'h0);
    wr(TH, 32'h0000_0041);
    pause(16);
    wr(TH, 32'h0000_005A);
    wait_frame();
    wait_frame();
    chk("gap zero", 32'h0, 32'(i_far.gap_r));
    // Guard of three bits with a character pending
    wr(GT, 32'h0000_0003);
    pause(48);
    wr(TH, 32'h0000_0041);
    pause(16);
    wr(TH, 32'h0000_005A);
    wait_frame();
    pause(16);
    rc(ST, 32'h0, "guard pending");
    wait_frame();
    chk("gap three", 32'h3, 32'(i_far.gap_r));
    pause(16);
    rc(ST, 32'h0000_0002, "guard last");
    pause(40);
    rc(ST, 32'h0000_0202, "tx idle");
    // Receiver off: a start bit is ignored
    i_far.send(8'h41, 1'b0);
    rc(ST, 32'h0000_0202, "rx off");
    // Two stop bits: completion waits for the second one
    wr(MD, 32'h0000_1100);
    i_far.send(8'h5A, 1'b0);
    rc(ST, 32'h0000_0202, "second stop");
    pause(8);
    rc(ST, 32'h0000_0203, "two stop rx");
    rc(RH, 32'h0000_005A, "two stop data");
    // Guard comes on top of both stop bits
    wr(TH, 32'h0000_0041);
    pause(16);
    wr(TH, 32'h0000_005A);
    wait_frame();
    wait_frame();
    chk("gap two stop", 32'h4, 32'(i_far.gap_r));
    close_out();
  end
endmodule : tb_top
`default_nettype wire
